//--- core/iso_driver_regs.svh
// Timing constants and reset values for the isolated driver status and protection logic
`ifndef ISO_DRIVER_REGS_SVH
`define ISO_DRIVER_REGS_SVH
`define CLK_PERIOD_NS        50
`define RISE_SLOPE_X100      355
`define RISE_OFFSET_NS       153
`define RISE_FLOOR_NS        235
`define FALL_DEGLITCH_NS     235
`define BURST_PERIOD_NS      25000
`define BURST_CYCLES         (`BURST_PERIOD_NS / `CLK_PERIOD_NS)
`define STARTUP_BURSTS       4
`define IND_GAP_NS           400
`define IND_GAP_CYCLES       (`IND_GAP_NS / `CLK_PERIOD_NS)
`define SUPPLY_LOSS_NS       2000
`define SUPPLY_LOSS_CYCLES   (`SUPPLY_LOSS_NS / `CLK_PERIOD_NS)
`define POWER_LEVEL_MAX      8'hFF
`define POWER_LEVEL_RST      8'h80
`endif

//--- core/iso_driver_pkg.sv
// Types shared by the isolated driver status and protection logic
package iso_driver_pkg;
   // Open-drain indicator pin: out level and active-low enable
   typedef struct packed {
      logic out;
      logic oe_n;
   } od_pin_s;
   // Secondary rail undervoltage comparator levels
   typedef struct packed {
      logic high_ok;
      logic mid_ok;
   } rails_s;
   typedef enum logic [1:0] {
      ST_OFF,
      ST_STARTUP,
      ST_RUN,
      ST_STANDBY
   } pwr_state_e;
   typedef enum logic [1:0] {
      SEQ_FAULT,
      SEQ_ALARM,
      SEQ_PWR_GOOD
   } seq_state_e;
endpackage : iso_driver_pkg

//--- core/deglitch_filter.sv
// Asymmetric counter deglitch filter for one comparator output
module deglitch_filter
   import iso_driver_pkg::*;
#(
   parameter int CW = 8
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // Settings in clock cycles
   input  wire logic [CW-1:0] rise_cycles,
   input  wire logic [CW-1:0] fall_cycles,
   // Data
   input  wire logic          raw,
   output logic               filt
);
   logic          filt_q, filt_d;
   logic [CW-1:0] cnt_q, cnt_d;

   // Count while input differs from output; change only after the held count
   always_comb begin
      filt_d = filt_q;
      cnt_d  = '0;
      if (raw != filt_q) begin
         cnt_d = cnt_q + 1'b1;
         if (cnt_d >= (raw ? rise_cycles : fall_cycles)) begin
            filt_d = raw;
            cnt_d  = '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         filt_q <= 1'b0;
         cnt_q  <= '0;
      end else begin
         filt_q <= filt_d;
         cnt_q  <= cnt_d;
      end
   end

   assign filt = filt_q;
endmodule : deglitch_filter

//--- core/isolated_driver_status_protection.sv
// Protection, burst power and status indicator logic of an isolated switch driver
// Operation
// - Alarm comparator never affects gate drive; only the alarm indicator shows it.
// - Rising comparator result propagates after max(3.55*R+153, 235) ns.
// - Falling comparator result is filtered by a fixed fall time.
// - One deglitch setting serves both fault and alarm comparators.
// - Alarm path does not latch; indicator follows the filtered state.
// - Filtered rising alarm is stretched to a sample; falls are not stretched.
// - Captured alarm pulls alarm indicator low; captured recovery releases it.
// - Stay disabled with gate drive low until primary supply is good.
// - Primary supply loss forces drive low; timeout forces it without message.
// - Primary undervoltage drives power-good, fault and alarm indicators low.
// - Gate drive goes high only with both secondary rails good.
// - Secondary rail loss drops drive at once; switching noise is ignored.
// - Overtemperature stops power transfer and holds drive low until cooled.
// - Supply present and chip-enable high transfer power; enable steers drive.
// - After power-up hold indicators low four burst periods, then release.
// - Power-good goes high only when both secondary rails are good.
// - Indicators update in order fault, alarm, power-good, 400 ns apart.
// - Fixed-period bursts, on-time from mid-rail loop, full power at start-up.
// - Chip-enable low enters standby, stops transfer, forces drive low.
// - Chip-enable low drives fault and alarm indicators low.
`include "iso_driver_regs.svh"
module isolated_driver_status_protection
   import iso_driver_pkg::*;
#(
   parameter int BURST_CYC   = `BURST_CYCLES,
   parameter int STARTUP_NB  = `STARTUP_BURSTS,
   parameter int GAP_CYC     = `IND_GAP_CYCLES,
   parameter int LOSS_CYC    = `SUPPLY_LOSS_CYCLES,
   parameter int BLANK_CYC   = 4,
   parameter int RES_KOHM_W  = 8
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // Primary side controls and supply sense
   input  wire logic                   chip_enable,
   input  wire logic                   enable,
   input  wire logic                   primary_supply_ok,
   input  wire logic                   over_temp,
   // Secondary side sense
   input  wire rails_s                 rails,
   input  wire logic                   mid_rail_low,
   input  wire logic                   fault_sense_input,
   input  wire logic                   alarm_sense_input,
   input  wire logic [RES_KOHM_W-1:0]  response_resistor,
   input  wire logic                   link_msg_valid,
   // Secondary outputs
   output logic                        gate_drive_output,
   output logic                        power_transfer,
   output logic [7:0]                  power_level,
   output logic                        fault_filtered,
   // Open-drain indicators
   output od_pin_s                     fault_indicator,
   output od_pin_s                     alarm_indicator,
   output od_pin_s                     power_good_indicator
);
   localparam int BCW = $clog2(BURST_CYC + 1);
   localparam int GCW = $clog2(GAP_CYC + 1) + 1;
   localparam int LCW = $clog2(LOSS_CYC + 1) + 1;

   // Rise deglitch in cycles, rounded up: max(3.55*R+153, 235) ns
   function automatic logic [7:0] rise_cycles_f(input logic [RES_KOHM_W-1:0] r);
      int ns_x100;
      int cyc;
      ns_x100 = `RISE_SLOPE_X100 * int'(r) + `RISE_OFFSET_NS * 100;
      if (ns_x100 < `RISE_FLOOR_NS * 100) begin
         ns_x100 = `RISE_FLOOR_NS * 100;
      end
      cyc = (ns_x100 + `CLK_PERIOD_NS * 100 - 1) / (`CLK_PERIOD_NS * 100);
      return (cyc > 255) ? 8'hFF : 8'(cyc);
   endfunction : rise_cycles_f

   localparam logic [7:0] FALL_CYC =
      8'((`FALL_DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);

   logic [7:0] rise_cyc;
   logic       alarm_filt;
   logic       fault_filt;
   assign rise_cyc = rise_cycles_f(response_resistor);

   // Shared setting feeds both filters; no separate control exists
   deglitch_filter #(.CW(8)) u_fault_flt (
      .clk         (clk),
      .rst         (rst),
      .rise_cycles (rise_cyc),
      .fall_cycles (FALL_CYC),
      .raw         (fault_sense_input),
      .filt        (fault_filt)
   );
   deglitch_filter #(.CW(8)) u_alarm_flt (
      .clk         (clk),
      .rst         (rst),
      .rise_cycles (rise_cyc),
      .fall_cycles (FALL_CYC),
      .raw         (alarm_sense_input),
      .filt        (alarm_filt)
   );

   // Power state, burst timer and start-up burst count
   pwr_state_e     st_q, st_d;
   logic [BCW-1:0] bcnt_q, bcnt_d;
   logic [2:0]     nburst_q, nburst_d;
   logic [7:0]     lvl_q, lvl_d;
   logic           burst_tick;
   logic           released;
   logic           active;

   assign burst_tick = (bcnt_q == BCW'(BURST_CYC - 1));
   assign active     = (st_q == ST_STARTUP) || (st_q == ST_RUN);
   assign released   = (st_q == ST_RUN);

   always_comb begin
      st_d     = st_q;
      bcnt_d   = burst_tick ? '0 : bcnt_q + 1'b1;
      nburst_d = nburst_q;
      lvl_d    = lvl_q;
      unique case (st_q)
         ST_OFF: begin
            bcnt_d   = '0;
            nburst_d = '0;
            if (primary_supply_ok) begin
               st_d = chip_enable ? ST_STARTUP : ST_STANDBY;
            end
         end
         ST_STARTUP: begin
            lvl_d = `POWER_LEVEL_MAX;
            if (burst_tick) begin
               nburst_d = nburst_q + 1'b1;
               if (nburst_q == 3'(STARTUP_NB - 1)) begin
                  st_d = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            // Crude mid-rail loop: one step per burst period
            if (burst_tick) begin
               if (mid_rail_low && lvl_q != 8'hFF) begin
                  lvl_d = lvl_q + 1'b1;
               end else if (!mid_rail_low && lvl_q != 8'h01) begin
                  lvl_d = lvl_q - 1'b1;
               end
            end
         end
         ST_STANDBY: begin
            bcnt_d   = '0;
            nburst_d = '0;
            if (chip_enable) begin
               st_d = ST_STARTUP;
            end
         end
      endcase
      if (!primary_supply_ok) begin
         st_d = ST_OFF;
      end else if (!chip_enable) begin
         st_d = ST_STANDBY;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q     <= ST_OFF;
         bcnt_q   <= '0;
         nburst_q <= '0;
         lvl_q    <= `POWER_LEVEL_RST;
      end else begin
         st_q     <= st_d;
         bcnt_q   <= bcnt_d;
         nburst_q <= nburst_d;
         lvl_q    <= lvl_d;
      end
   end

   // Burst on-time is a fraction of the period set by the level
   logic on_window;
   assign on_window = ({bcnt_q, 8'h00} < ((BCW+8)'(BURST_CYC) * (BCW+8)'(lvl_q)));

   // Stretch rising alarm and fault until the next snapshot; sample once per burst
   logic alm_str_q, alm_str_d, flt_str_q, flt_str_d;
   logic alm_smp_q, alm_smp_d, flt_smp_q, flt_smp_d;
   always_comb begin
      alm_str_d = (alarm_filt || alm_str_q) && !burst_tick;
      flt_str_d = (fault_filt || flt_str_q) && !burst_tick;
      alm_smp_d = alm_smp_q;
      flt_smp_d = flt_smp_q;
      if (burst_tick) begin
         alm_smp_d = alarm_filt || alm_str_q;
         flt_smp_d = fault_filt || flt_str_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         alm_str_q <= 1'b0;
         flt_str_q <= 1'b0;
         alm_smp_q <= 1'b0;
         flt_smp_q <= 1'b0;
      end else begin
         alm_str_q <= alm_str_d;
         flt_str_q <= flt_str_d;
         alm_smp_q <= alm_smp_d;
         flt_smp_q <= flt_smp_d;
      end
   end

   // Indicator sequencer: fault, then alarm, then power-good, one gap apart
   seq_state_e     seq_q, seq_d;
   logic [GCW-1:0] gap_q, gap_d;
   logic           flt_ind_q, flt_ind_d;  // 1 = released high
   logic           alm_ind_q, alm_ind_d;
   logic           pg_ind_q, pg_ind_d;
   logic           pg_status;
   assign pg_status = rails.high_ok && rails.mid_ok;

   always_comb begin
      seq_d     = seq_q;
      gap_d     = gap_q;
      flt_ind_d = flt_ind_q;
      alm_ind_d = alm_ind_q;
      pg_ind_d  = pg_ind_q;
      if (!released) begin
         seq_d     = SEQ_FAULT;
         gap_d     = '0;
         flt_ind_d = 1'b0;
         alm_ind_d = 1'b0;
         pg_ind_d  = 1'b0;
      end else if (gap_q != '0) begin
         gap_d = gap_q - 1'b1;
      end else begin
         gap_d = GCW'(GAP_CYC - 1);
         unique case (seq_q)
            SEQ_FAULT: begin
               flt_ind_d = !flt_smp_q;
               seq_d     = SEQ_ALARM;
            end
            SEQ_ALARM: begin
               alm_ind_d = !alm_smp_q;
               seq_d     = SEQ_PWR_GOOD;
            end
            SEQ_PWR_GOOD: begin
               pg_ind_d = pg_status;
               seq_d    = SEQ_FAULT;
            end
            default: seq_d = SEQ_FAULT;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         seq_q     <= SEQ_FAULT;
         gap_q     <= '0;
         flt_ind_q <= 1'b0;
         alm_ind_q <= 1'b0;
         pg_ind_q  <= 1'b0;
      end else begin
         seq_q     <= seq_d;
         gap_q     <= gap_d;
         flt_ind_q <= flt_ind_d;
         alm_ind_q <= alm_ind_d;
         pg_ind_q  <= pg_ind_d;
      end
   end

   // Secondary side: rail blanking after each drive edge, and link loss timeout
   logic [2:0]     blank_q, blank_d;
   logic [LCW-1:0] loss_q, loss_d;
   logic           drv_q, drv_d;
   logic           rails_ok;
   logic           loss_out;
   logic           allow;

   assign rails_ok = (rails.high_ok && rails.mid_ok) || (blank_q != '0);
   assign loss_out = (loss_q >= LCW'(LOSS_CYC));
   // Alarm result deliberately absent from the drive condition
   assign allow = active && !over_temp && !fault_filt && !loss_out;

   always_comb begin
      loss_d  = link_msg_valid ? '0 : (loss_out ? loss_q : loss_q + 1'b1);
      drv_d   = enable && allow && rails_ok;
      blank_d = (blank_q != '0) ? blank_q - 1'b1 : blank_q;
      if (drv_d != drv_q) begin
         blank_d = 3'(BLANK_CYC);
      end
      if (!drv_q && !(rails.high_ok && rails.mid_ok)) begin
         drv_d = 1'b0;
      end
      // Chip-enable acts at once; the power state only follows one cycle later
      if (!primary_supply_ok || !chip_enable) begin
         drv_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         blank_q <= '0;
         loss_q  <= '0;
         drv_q   <= 1'b0;
      end else begin
         blank_q <= blank_d;
         loss_q  <= loss_d;
         drv_q   <= drv_d;
      end
   end

   // Outputs; open-drain enable low means the pin is pulled low
   assign gate_drive_output = drv_q;
   assign power_transfer    = active && !over_temp && on_window;
   assign power_level       = lvl_q;
   assign fault_filtered    = fault_filt;
   assign fault_indicator      = '{out: 1'b0, oe_n: flt_ind_q};
   assign alarm_indicator      = '{out: 1'b0, oe_n: alm_ind_q};
   assign power_good_indicator = '{out: 1'b0, oe_n: pg_ind_q};
endmodule : isolated_driver_status_protection

//--- verification/controller_model.sv
// Behavioural system controller: drives the enables and reads the open-drain indicators
module controller_model
   import iso_driver_pkg::*;
(
   // Requests from the bench
   input  wire logic    ce_req,
   input  wire logic    en_req,
   // Controls to the block
   output logic         chip_enable,
   output logic         enable,
   // Indicator pins
   input  wire od_pin_s fault_indicator,
   input  wire od_pin_s alarm_indicator,
   input  wire od_pin_s power_good_indicator,
   // Resolved line levels
   output logic         fault_level,
   output logic         alarm_level,
   output logic         pwr_good_level
);
   // The controller steers power transfer and drive with plain levels
   assign chip_enable = ce_req;
   assign enable      = en_req;
   // A released line floats up to its pull-up, never to a stale value
   assign fault_level = fault_indicator.oe_n ? 1'h1 : fault_indicator.out;
   assign alarm_level = alarm_indicator.oe_n ? 1'h1 : alarm_indicator.out;
   assign pwr_good_level = power_good_indicator.oe_n ? 1'h1 : power_good_indicator.out;
endmodule : controller_model

//--- verification/iso_driver_props.sv
// Port checker for the isolated driver protection and status block
module iso_driver_props
   import iso_driver_pkg::*;
#(
   parameter int BURST_CYC   = 20,
   parameter int STARTUP_NB  = 4,
   parameter int LOSS_CYC    = 10,
   parameter int RES_KOHM_W  = 8
) (
   // Clock and reset
   input wire logic                   clk,
   input wire logic                   rst,
   // Controls and sense
   input wire logic                   chip_enable,
   input wire logic                   enable,
   input wire logic                   primary_supply_ok,
   input wire logic                   over_temp,
   input wire rails_s                 rails,
   input wire logic                   fault_sense_input,
   input wire logic [RES_KOHM_W-1:0]  response_resistor,
   input wire logic                   link_msg_valid,
   // Block outputs
   input wire logic                   gate_drive_output,
   input wire logic                   power_transfer,
   input wire logic                   fault_filtered,
   input wire od_pin_s                fault_indicator,
   input wire od_pin_s                alarm_indicator,
   input wire od_pin_s                power_good_indicator
);
   logic [7:0]  hi_q, hi_d, lo_q, lo_d, loss_q, loss_d;
   logic [15:0] up_q, up_d;
   int          rise_c;
   // Run lengths of fault input, link silence and powered time; saturate so they never wrap
   always_comb begin
      hi_d   = fault_sense_input ? hi_q + {7'h0, hi_q != 8'hFF} : 8'h0;
      lo_d   = fault_sense_input ? 8'h0 : lo_q + {7'h0, lo_q != 8'hFF};
      loss_d = link_msg_valid ? 8'h0 : loss_q + {7'h0, loss_q != 8'hFF};
      up_d   = (primary_supply_ok && chip_enable) ? up_q + {15'h0, up_q != 16'hFFFF} : 16'h0;
      rise_c = (355 * int'(response_resistor) + 15300 + 4999) / 5000;
      if (rise_c < 5) begin
         rise_c = 5;
      end
   end
   // Counter registers
   always_ff @(posedge clk) begin
      hi_q   <= rst ? 8'h0 : hi_d;
      lo_q   <= rst ? 8'h0 : lo_d;
      loss_q <= rst ? 8'h0 : loss_d;
      up_q   <= rst ? 16'h0 : up_d;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_SUPPLY_OFF: assert property (!primary_supply_ok |=> !gate_drive_output)
      else $error("drive high without primary supply");
   AST_LINK_LOSS: assert property (loss_q > LOSS_CYC + 1 |-> !gate_drive_output)
      else $error("drive high after link timeout");
   AST_UV_IND: assert property (!primary_supply_ok [*3] |-> !fault_indicator.oe_n
      && !alarm_indicator.oe_n && !power_good_indicator.oe_n)
      else $error("indicator released without supply");
   AST_DRV_RISE: assert property ($rose(gate_drive_output) |-> $past(enable && chip_enable
      && primary_supply_ok && rails.high_ok && rails.mid_ok))
      else $error("drive rose without its causes");
   AST_RAIL_LOSS: assert property (!(rails.high_ok && rails.mid_ok) [*6] |-> !gate_drive_output)
      else $error("drive high on bad rails");
   AST_HOT: assert property (over_temp [*2] |-> !gate_drive_output && !power_transfer)
      else $error("drive or transfer while hot");
   AST_STARTUP: assert property (up_q != 16'h0 && int'(up_q) < STARTUP_NB * BURST_CYC
      |-> !fault_indicator.oe_n && !alarm_indicator.oe_n && !power_good_indicator.oe_n)
      else $error("indicator released during start-up");
   AST_PG_RAILS: assert property ($rose(power_good_indicator.oe_n) |-> $past(rails.high_ok
      && rails.mid_ok))
      else $error("power-good released on bad rails");
   AST_STANDBY: assert property (!chip_enable [*3] |-> !gate_drive_output && !power_transfer
      && !fault_indicator.oe_n && !alarm_indicator.oe_n)
      else $error("standby not honoured");
   AST_RISE_FILT: assert property ($rose(fault_filtered) |-> int'(hi_q) >= rise_c - 1)
      else $error("fault passed before rise time");
   AST_FALL_FILT: assert property ($fell(fault_filtered) |-> lo_q >= 8'h4)
      else $error("fault cleared before fall time");
endmodule : iso_driver_props

bind isolated_driver_status_protection iso_driver_props #(.BURST_CYC(BURST_CYC),
   .STARTUP_NB(STARTUP_NB), .LOSS_CYC(LOSS_CYC), .RES_KOHM_W(RES_KOHM_W))
   u_iso_driver_props (.clk, .rst, .chip_enable, .enable, .primary_supply_ok, .over_temp,
   .rails, .fault_sense_input, .response_resistor, .link_msg_valid, .gate_drive_output,
   .power_transfer, .fault_filtered, .fault_indicator, .alarm_indicator,
   .power_good_indicator);

//--- verification/isolated_driver_status_protection_test.sv
// Self-checking bench for the isolated driver protection and status block
module isolated_driver_status_protection_test
   import iso_driver_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BC   = 20;
   localparam int GAP  = 3;
   localparam int LOSS = 10;
   logic       clk = 1'h0, rst = 1'h1, ce_req = 1'h0, en_req = 1'h0, supply = 1'h0;
   logic       hot = 1'h0, mid_low = 1'h0, flt_in = 1'h0, alm_in = 1'h0, link = 1'h1;
   rails_s     rails = 2'h3;
   logic [7:0] res_kohm = 8'h0;
   logic [7:0] level;
   logic       chip_enable, enable, drive, ptx, flt_f, fl, al, pl;
   od_pin_s    fi, ai, pi;
   int         num_errors = 0, n_tests = 0, n, rc;
   int         gap_q[$] = '{GAP, GAP};

   controller_model u_controller_model (.ce_req, .en_req, .chip_enable, .enable,
      .fault_indicator(fi), .alarm_indicator(ai), .power_good_indicator(pi),
      .fault_level(fl), .alarm_level(al), .pwr_good_level(pl));
   isolated_driver_status_protection #(.BURST_CYC(BC), .GAP_CYC(GAP), .LOSS_CYC(LOSS))
      u_isolated_driver_status_protection (.clk, .rst, .chip_enable, .enable,
      .primary_supply_ok(supply), .over_temp(hot), .rails, .mid_rail_low(mid_low),
      .fault_sense_input(flt_in), .alarm_sense_input(alm_in), .response_resistor(res_kohm),
      .link_msg_valid(link), .gate_drive_output(drive), .power_transfer(ptx),
      .power_level(level), .fault_filtered(flt_f), .fault_indicator(fi),
      .alarm_indicator(ai), .power_good_indicator(pi));

   // Clock, and a loop error input that wanders so the regulator is exercised
   always #25 clk = ~clk;
   always @(negedge clk) mid_low <= 1'($urandom % 2);

   // Model of the rise deglitch in whole cycles, rounded up
   function automatic int rise_cyc(input int r);
      int x;
      x = 355 * r + 15300;
      if (x < 23500) begin
         x = 23500;
      end
      return (x + 4999) / 5000;
   endfunction : rise_cyc

   function automatic logic sig(input int w);
      case (w)
         0: return fl;
         1: return al;
         2: return pl;
         3: return drive;
         default: return flt_f;
      endcase
   endfunction : sig

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Bounded wait on a settled output; the cycles taken land in n
   task automatic wait_sig(input string nm, input int w, input logic v, input int lim);
      n = 0;
      while (sig(w) !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(nm, {7'h0, v}, {7'h0, sig(w)});
   endtask : wait_sig

   task automatic final_report();
      if (num_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      #1000000;
      num_errors++;
      final_report();
   end

   initial begin
      void'($urandom(97));
      repeat (5) @(negedge clk);
      rst = 1'h0;
      // Power up: indicators held through start-up, then released in order
      supply = 1'h1;
      ce_req = 1'h1;
      repeat (4 * BC - 2) @(negedge clk);
      chk("held", 8'h0, {5'h0, fl, al, pl});
      chk("level", 8'hFF, level);
      chk("ptx_full", 8'h1, {7'h0, ptx});
      wait_sig("fault_rel", 0, 1'h1, 20);
      wait_sig("alarm_rel", 1, 1'h1, 10);
      chk("gap_a", 8'(gap_q.pop_front()), 8'(n));
      wait_sig("pg_rel", 2, 1'h1, 10);
      chk("gap_p", 8'(gap_q.pop_front()), 8'(n));
      // Drive follows enable; the alarm shows only on its indicator
      res_kohm = 8'($urandom % 64);
      rc = rise_cyc(int'(res_kohm));
      en_req = 1'h1;
      wait_sig("drive_on", 3, 1'h1, 4);
      alm_in = 1'h1;
      wait_sig("alarm_low", 1, 1'h0, rc + 2 * BC + 4 * GAP);
      chk("drive_alm", 8'h1, {7'h0, drive});
      alm_in = 1'h0;
      wait_sig("alarm_rec", 1, 1'h1, 5 + 2 * BC + 4 * GAP);
      // A brief alarm, far shorter than a burst, must still be captured
      alm_in = 1'h1;
      repeat (rc + 2) @(negedge clk);
      alm_in = 1'h0;
      wait_sig("alarm_short", 1, 1'h0, 2 * BC + 4 * GAP);
      wait_sig("alarm_back", 1, 1'h1, 2 * BC + 4 * GAP);
      // Fault filter timing over random resistor settings
      for (int i = 0; i < 4; i++) begin
         res_kohm = 8'($urandom);
         rc = rise_cyc(int'(res_kohm));
         repeat (8) @(negedge clk);
         flt_in = 1'h1;
         repeat (rc - 2) @(negedge clk);
         flt_in = 1'h0;
         chk("glitch", 8'h0, {7'h0, flt_f});
         repeat (8) @(negedge clk);
         flt_in = 1'h1;
         wait_sig("flt_rise", 4, 1'h1, rc + 2);
         chk("rise_len", 8'h1, {7'h0, n >= rc - 1});
         flt_in = 1'h0;
         wait_sig("flt_fall", 4, 1'h0, 8);
         chk("fall_len", 8'h1, {7'h0, n >= 4});
      end
      // Rail loss drops the drive; a short dip right after a drive edge is ignored
      rails = 2'h0;
      repeat (8) @(negedge clk);
      chk("drive_rail", 8'h0, {7'h0, drive});
      rails = 2'h3;
      wait_sig("drive_back", 3, 1'h1, 8);
      en_req = 1'h0;
      repeat (3) @(negedge clk);
      en_req = 1'h1;
      wait_sig("drive_edge", 3, 1'h1, 4);
      rails = 2'h1;
      repeat (2) @(negedge clk);
      rails = 2'h3;
      chk("drive_dip", 8'h1, {7'h0, drive});
      // Over-temperature and link silence each force the drive low
      hot = 1'h1;
      repeat (3) @(negedge clk);
      chk("drive_hot", 8'h0, {6'h0, drive, ptx});
      hot = 1'h0;
      wait_sig("drive_cool", 3, 1'h1, 4 * BC + 8);
      link = 1'h0;
      repeat (LOSS + 3) @(negedge clk);
      chk("drive_loss", 8'h0, {7'h0, drive});
      link = 1'h1;
      wait_sig("drive_link", 3, 1'h1, 8);
      // Standby and supply loss pull the indicators low
      ce_req = 1'h0;
      repeat (4) @(negedge clk);
      chk("standby", 8'h0, {4'h0, fl, al, drive, ptx});
      ce_req = 1'h1;
      supply = 1'h0;
      repeat (4) @(negedge clk);
      chk("uvlo", 8'h0, {4'h0, fl, al, pl, drive});
      // Recovery repeats start-up; power-good then tracks the rails
      supply = 1'h1;
      wait_sig("pg_up", 2, 1'h1, 5 * BC + 4 * GAP);
      rails = 2'h2;
      wait_sig("pg_rail", 2, 1'h0, 2 * BC + 4 * GAP);
      final_report();
   end
endmodule : isolated_driver_status_protection_test
